// File: cpu_alu_consts.vh
// Purpose: constants of the cpu execution datapath
// Assumes: included by the datapath only
// Notes:   byte offsets on a 32-bit Avalon-MM slave
`ifndef CPU_ALU_CONSTS_VH
`define CPU_ALU_CONSTS_VH
// ==========================================
// register offsets
`define OFS_CMD   6'h00
`define OFS_FLAGS 6'h04
`define OFS_IMM   6'h08
`define OFS_DISP  6'h0c
`define OFS_GPR   6'h20
// ==========================================
// flag bit positions
`define F_C 0
`define F_V 1
`define F_Z 2
`define F_N 3
`define F_H 5
`define FLAGS_RST 8'h00
// ==========================================
// command word fields
`define C_OP   5:0
`define C_WORD 6
`define C_IMM  7
`define C_MEM  8
`define C_DST  12:9
`define C_SRC  16:13
`define C_MODE 18:17
`define C_ABS8 19
`define M_IND  2'h0
`define M_D16  2'h1
`define M_D8   2'h2
`define M_ABS  2'h3
// ==========================================
// operations
`define OP_MOV        6'h00
`define OP_LD         6'h01
`define OP_ST         6'h02
`define OP_LD_POSTINC 6'h03
`define OP_ST_PREDEC  6'h04
`define OP_POP        6'h05
`define OP_PUSH       6'h06
`define OP_ADD        6'h07
`define OP_ADD_C      6'h08
`define OP_SUB        6'h09
`define OP_SUB_C      6'h0a
`define OP_CMP        6'h0b
`define OP_NEG        6'h0c
`define OP_INC        6'h0d
`define OP_DEC        6'h0e
`define OP_ADDR_ADD   6'h0f
`define OP_ADDR_SUB   6'h10
`define OP_DEC_ADJ_A  6'h11
`define OP_DEC_ADJ_S  6'h12
`define OP_UMUL       6'h13
`define OP_UDIV       6'h14
`define OP_AND        6'h15
`define OP_OR         6'h16
`define OP_XOR        6'h17
`define OP_NOT        6'h18
`define OP_BIT_ONE    6'h19
`define OP_BIT_ZERO   6'h1a
`define OP_BIT_INV    6'h1b
`define OP_BIT_TEST   6'h1c
`define OP_BIT_TO_C   6'h1d
`define OP_IBIT_TO_C  6'h1e
`define OP_C_TO_BIT   6'h1f
`define OP_IC_TO_BIT  6'h20
`define OP_C_AND_BIT  6'h21
`define OP_C_AND_IBIT 6'h22
`define OP_C_OR_BIT   6'h23
`define OP_C_OR_IBIT  6'h24
// ==========================================
// execution state counts
`define ST_REG    5'd2
`define ST_WIMM   5'd4
`define ST_IND    5'd4
`define ST_D16    5'd6
`define ST_PTR    5'd6
`define ST_MULDIV 5'd14
`define ST_BITRMW 5'd8
`define ST_BITRD  5'd6
`endif

// File: cpu_alu_bit_datapath.v
// Purpose: execution datapath, moves, arithmetic, logic and bit ops
// Assumes: memory port answers with memAck; software issues via Avalon
// Notes:   command accepted only while idle; writes stall when busy
//
// Behaviour
// - register operands are 8 or 16 bits
// - immediates of 3, 8 and 16 bits
// - 8/16-bit displacement and absolute addressing
// - each flag follows its per-operation treatment
// - moves set N Z, clear V
// - post-increment load bumps pointer, 6 states
// - pre-decrement store lowers pointer, then writes
// - pop and push move stack pointer by two
// - decimal adjust corrects byte, sets N Z
// - 8x8 unsigned multiply, 14 states, flags kept
// - 16/8 unsigned divide, remainder high, quotient low
// - byte logic ops set N Z, clear V
// - bit force one, register or memory byte
// - bit force zero, same timing, flags kept
// - bit invert writes byte back, flags kept
// - bit test puts inverted bit in Z
// - bit to carry, plain or inverted
// - carry to bit, plain or inverted
// - carry ANDed with bit or its inverse
// - carry ORed with bit or its inverse
// - word arithmetic half carry from bit 11, except carry-chained ops (bit 3)
// - carry-chained ops keep Z only on zero
// - divide N from divisor sign, Z divisor zero
// - decimal adjust add sets carry from correction
`timescale 1ns/1ps
`include "cpu_alu_consts.vh"

module cpu_alu_bit_datapath (
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire        avs_waitrequest,
   output wire        memReq,
   output wire        memWe,
   output wire        memByte,
   output wire [15:0] memAddr,
   output wire [15:0] memWdata,
   input  wire [15:0] memRdata,
   input  wire        memAck
);

   localparam S_IDLE = 3'h0, S_ADR = 3'h1, S_RD = 3'h2;
   localparam S_EXE  = 3'h3, S_WR  = 3'h4, S_HOLD = 3'h5;

   // ==========================================
   // functions
   function [18:0] arith;
      input [15:0] a;
      input [15:0] b;
      input        ci;
      input        sub;
      input        wd;
      reg   [15:0] bx;
      reg          cx;
      reg   [16:0] s;
      reg   [8:0]  s8;
      reg   [12:0] hs;
      reg          co, hc, ov;
      begin
         bx = sub ? ~b : b;
         cx = sub ? ~ci : ci;
         s  = {1'b0, a} + {1'b0, bx} + {16'h0000, cx};
         s8 = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cx};
         if (wd) begin
            hs = {1'b0, a[11:0]} + {1'b0, bx[11:0]} + {12'h000, cx};
            hc = hs[12];
            co = s[16];
            ov = (a[15] == bx[15]) & (s[15] != a[15]);
         end else begin
            hs = {9'h000, a[3:0]} + {9'h000, bx[3:0]} + {12'h000, cx};
            hc = hs[4];
            co = s8[8];
            ov = (a[7] == bx[7]) & (s8[7] != a[7]);
         end
         arith = {hc ^ sub, ov, co ^ sub, wd ? s[15:0] : {8'h00, s8[7:0]}};
      end
   endfunction

   function [1:0] negZero;
      input [15:0] r;
      input        wd;
      negZero = wd ? {r[15], r == 16'h0000} : {r[7], r[7:0] == 8'h00};
   endfunction

   function [15:0] laneMerge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  be;
      laneMerge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   // ==========================================
   // state
   reg  [15:0] gpr_ff [0:7];
   reg  [7:0]  flags_ff;
   reg  [15:0] imm_ff, disp_ff;
   reg  [19:0] cmd_ff;
   reg  [2:0]  state_ff;
   reg  [2:0]  nxt_state;
   reg  [4:0]  cnt_ff;
   reg  [15:0] addr_ff, wd_ff, md_ff;
   reg         ans_ff;
   reg  [31:0] rdata_ff;
   integer     i;

   // ==========================================
   // operand selection
   wire [5:0]  op      = cmd_ff[`C_OP];
   wire        word    = cmd_ff[`C_WORD];
   wire        useImm  = cmd_ff[`C_IMM];
   wire [3:0]  dIdx    = cmd_ff[`C_DST];
   wire [3:0]  sIdx    = cmd_ff[`C_SRC];
   wire [1:0]  mode    = cmd_ff[`C_MODE];
   wire [15:0] dW      = gpr_ff[dIdx[2:0]];
   wire [15:0] sW      = gpr_ff[sIdx[2:0]];
   wire [7:0]  d8      = dIdx[3] ? dW[7:0] : dW[15:8];
   wire [7:0]  s8      = sIdx[3] ? sW[7:0] : sW[15:8];
   wire [15:0] aOp     = word ? dW : {8'h00, d8};
   wire [15:0] immV    = word ? imm_ff : {8'h00, imm_ff[7:0]};
   wire [15:0] bOp     = useImm ? immV : (word ? sW : {8'h00, s8});
   wire        stk     = (op == `OP_POP) | (op == `OP_PUSH);
   wire        isBit   = op >= `OP_BIT_ONE;
   wire        memBit  = isBit & cmd_ff[`C_MEM];
   wire        bitRmw  = memBit & ((op <= `OP_BIT_INV) | (op == `OP_C_TO_BIT) | (op == `OP_IC_TO_BIT));
   wire        loadOp  = (op == `OP_LD) | (op == `OP_LD_POSTINC);
   wire        memRead = loadOp | (op == `OP_POP) | memBit;
   wire        memWr   = (op == `OP_ST) | (op == `OP_ST_PREDEC) | (op == `OP_PUSH) | bitRmw;
   wire [2:0]  baseIdx = stk ? 3'h7 : (loadOp ? sIdx[2:0] : dIdx[2:0]);
   wire [15:0] base    = gpr_ff[baseIdx];
   wire [15:0] step    = (word | stk) ? 16'h0002 : 16'h0001;
   wire        busy    = state_ff != S_IDLE;
   reg  [15:0] ea;
   reg  [4:0]  need;

   // ==========================================
   // effective address
   always @* begin
      case (mode)
         `M_D16:  ea = base + disp_ff;
         `M_D8:   ea = base + {{8{disp_ff[7]}}, disp_ff[7:0]};
         `M_ABS:  ea = cmd_ff[`C_ABS8] ? {8'hff, disp_ff[7:0]} : disp_ff;
         default: ea = base;
      endcase
      if ((op == `OP_ST_PREDEC) | (op == `OP_PUSH)) begin
         ea = base - step;
      end else if ((op == `OP_LD_POSTINC) | (op == `OP_POP)) begin
         ea = base;
      end
   end

   // ==========================================
   // state counts
   always @* begin
      if ((op == `OP_UMUL) | (op == `OP_UDIV)) begin
         need = `ST_MULDIV;
      end else if (memBit) begin
         need = bitRmw ? `ST_BITRMW : `ST_BITRD;
      end else if ((op == `OP_LD_POSTINC) | (op == `OP_ST_PREDEC) | stk) begin
         need = `ST_PTR;
      end else if ((op == `OP_LD) | (op == `OP_ST)) begin
         need = (mode == `M_IND) | ((mode == `M_ABS) & cmd_ff[`C_ABS8]) ? `ST_IND : `ST_D16;
      end else if ((op == `OP_MOV) & word & useImm) begin
         need = `ST_WIMM;
      end else begin
         need = `ST_REG;
      end
   end

   // ==========================================
   // execution
   wire        isSub = (op == `OP_SUB) | (op == `OP_SUB_C) | (op == `OP_CMP) | (op == `OP_NEG) | (op == `OP_DEC);
   wire        chain = (op == `OP_ADD_C) | (op == `OP_SUB_C);
   wire        incDec = (op == `OP_INC) | (op == `OP_DEC);
   wire [15:0] arA = (op == `OP_NEG) ? 16'h0000 : aOp;
   wire [15:0] arB = (op == `OP_NEG) ? aOp : (incDec ? 16'h0001 : bOp);
   wire [18:0] ar  = arith(arA, arB, chain & flags_ff[`F_C], isSub, word & ~incDec & ~chain);
   wire [2:0]  bn  = useImm ? imm_ff[2:0] : s8[2:0];
   wire [7:0]  ob  = memBit ? md_ff[7:0] : d8;
   wire [7:0]  msk = 8'h01 << bn;
   wire        selBit = ob[bn];
   wire        adjL = flags_ff[`F_H] | (d8[3:0] > 4'h9);
   wire        adjH = flags_ff[`F_C] | (d8 > 8'h99);
   wire [15:0] mulP = {8'h00, dW[7:0]} * {8'h00, s8};
   wire [15:0] quo  = (s8 == 8'h00) ? 16'h00ff : dW / {8'h00, s8};
   wire [15:0] rem  = (s8 == 8'h00) ? dW : dW % {8'h00, s8};
   reg  [15:0] res, ptrV, nWd;
   reg  [7:0]  nFl;
   reg         wrD, wrW, wrP;

   always @* begin
      res  = ar[15:0];
      nFl  = flags_ff;
      wrD  = 1'b0;
      wrW  = 1'b0;
      wrP  = 1'b0;
      ptrV = base;
      nWd  = word ? sW : {8'h00, s8};
      case (op)
         `OP_MOV, `OP_LD, `OP_LD_POSTINC, `OP_POP, `OP_ST, `OP_ST_PREDEC, `OP_PUSH: begin
            if (op == `OP_MOV) begin
               res = bOp;
            end else if (memRead) begin
               res = word | stk ? md_ff : {8'h00, md_ff[7:0]};
            end else begin
               res = nWd;
            end
            {nFl[`F_N], nFl[`F_Z]} = negZero(res, word | stk);
            nFl[`F_V] = 1'b0;
            wrD = memRead | (op == `OP_MOV);
            wrP = (op == `OP_LD_POSTINC) | (op == `OP_ST_PREDEC) | stk;
            ptrV = (op == `OP_LD_POSTINC) | (op == `OP_POP) ? base + step : base - step;
         end
         `OP_ADD, `OP_SUB, `OP_CMP, `OP_NEG, `OP_ADD_C, `OP_SUB_C: begin
            nFl[`F_H] = ar[18];
            nFl[`F_V] = ar[17];
            nFl[`F_C] = ar[16];
            {nFl[`F_N], nFl[`F_Z]} = negZero(res, word & ~chain);
            if (chain) begin
               nFl[`F_Z] = (res[7:0] == 8'h00) & flags_ff[`F_Z];
            end
            wrD = op != `OP_CMP;
         end
         `OP_INC, `OP_DEC: begin
            {nFl[`F_N], nFl[`F_Z]} = negZero(res, 1'b0);
            nFl[`F_V] = ar[17];
            wrD = 1'b1;
         end
         `OP_ADDR_ADD, `OP_ADDR_SUB: begin
            res = (op == `OP_ADDR_ADD) ? dW + (imm_ff[1] ? 16'h0002 : 16'h0001)
                                       : dW - (imm_ff[1] ? 16'h0002 : 16'h0001);
            wrW = 1'b1;
         end
         `OP_DEC_ADJ_A, `OP_DEC_ADJ_S: begin
            if (op == `OP_DEC_ADJ_A) begin
               res = {8'h00, d8 + (adjH ? 8'h60 : 8'h00) + (adjL ? 8'h06 : 8'h00)};
               nFl[`F_C] = adjH;
            end else begin
               res = {8'h00, d8 - (flags_ff[`F_C] ? 8'h60 : 8'h00) - (flags_ff[`F_H] ? 8'h06 : 8'h00)};
            end
            {nFl[`F_N], nFl[`F_Z]} = negZero(res, 1'b0);
            wrD = 1'b1;
         end
         `OP_UMUL: begin
            res = mulP;
            wrW = 1'b1;
         end
         `OP_UDIV: begin
            res = {rem[7:0], quo[7:0]};
            nFl[`F_N] = s8[7];
            nFl[`F_Z] = s8 == 8'h00;
            wrW = 1'b1;
         end
         `OP_AND, `OP_OR, `OP_XOR, `OP_NOT: begin
            res = {8'h00, (op == `OP_AND) ? d8 & bOp[7:0] : (op == `OP_OR) ? d8 | bOp[7:0] :
                          (op == `OP_XOR) ? d8 ^ bOp[7:0] : ~d8};
            {nFl[`F_N], nFl[`F_Z]} = negZero(res, 1'b0);
            nFl[`F_V] = 1'b0;
            wrD = 1'b1;
         end
         `OP_BIT_ONE, `OP_BIT_ZERO, `OP_BIT_INV, `OP_C_TO_BIT, `OP_IC_TO_BIT: begin
            case (op)
               `OP_BIT_ONE:  res = {8'h00, ob | msk};
               `OP_BIT_ZERO: res = {8'h00, ob & ~msk};
               `OP_BIT_INV:  res = {8'h00, ob ^ msk};
               `OP_C_TO_BIT: res = {8'h00, flags_ff[`F_C] ? ob | msk : ob & ~msk};
               default:      res = {8'h00, flags_ff[`F_C] ? ob & ~msk : ob | msk};
            endcase
            wrD = ~memBit;
            nWd = res;
         end
         `OP_BIT_TEST: nFl[`F_Z] = ~selBit;
         `OP_BIT_TO_C: nFl[`F_C] = selBit;
         `OP_IBIT_TO_C: nFl[`F_C] = ~selBit;
         `OP_C_AND_BIT: nFl[`F_C] = flags_ff[`F_C] & selBit;
         `OP_C_AND_IBIT: nFl[`F_C] = flags_ff[`F_C] & ~selBit;
         `OP_C_OR_BIT: nFl[`F_C] = flags_ff[`F_C] | selBit;
         `OP_C_OR_IBIT: nFl[`F_C] = flags_ff[`F_C] | ~selBit;
         default: nFl = flags_ff;
      endcase
   end

   // ==========================================
   // sequencer
   wire done = cnt_ff >= need - 5'd1;
   wire req = avs_read | avs_write;
   wire stall = avs_write & busy;
   wire take = req & ~ans_ff & ~stall;
   wire wrNow = avs_write & ans_ff;
   wire start = wrNow & (avs_address == `OFS_CMD);

   always @* begin
      case (state_ff)
         S_IDLE: nxt_state = start ? S_ADR : S_IDLE;
         S_ADR:  nxt_state = memRead ? S_RD : S_EXE;
         S_RD:   nxt_state = memAck ? S_EXE : S_RD;
         S_EXE:  nxt_state = memWr ? S_WR : (done ? S_IDLE : S_HOLD);
         S_WR:   nxt_state = memAck ? (done ? S_IDLE : S_HOLD) : S_WR;
         S_HOLD: nxt_state = done ? S_IDLE : S_HOLD;
         default: nxt_state = S_IDLE;
      endcase
   end

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= S_IDLE;
         cnt_ff   <= 5'd0;
         addr_ff  <= 16'h0000;
         wd_ff    <= 16'h0000;
         md_ff    <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= (state_ff == S_IDLE) ? 5'd0 : cnt_ff + 5'd1;
         if (state_ff == S_ADR) addr_ff <= ea;
         if ((state_ff == S_RD) & memAck) md_ff <= memRdata;
         if (state_ff == S_EXE) wd_ff <= nWd;
      end
   end

   // ==========================================
   // register file, flags and bus slave
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         for (i = 0; i < 8; i = i + 1) begin
            gpr_ff[i] <= 16'h0000;
         end
         flags_ff <= `FLAGS_RST;
         imm_ff   <= 16'h0000;
         disp_ff  <= 16'h0000;
         cmd_ff   <= 20'h00000;
         ans_ff   <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ans_ff <= take;
         if (take) begin
            if (avs_address == `OFS_CMD) begin
               rdata_ff <= {busy, 11'h000, cmd_ff};
            end else if (avs_address == `OFS_FLAGS) begin
               rdata_ff <= {24'h000000, flags_ff};
            end else if (avs_address == `OFS_IMM) begin
               rdata_ff <= {16'h0000, imm_ff};
            end else if (avs_address == `OFS_DISP) begin
               rdata_ff <= {16'h0000, disp_ff};
            end else if (avs_address[5] & (avs_address[1:0] == 2'h0)) begin
               rdata_ff <= {16'h0000, gpr_ff[avs_address[4:2]]};
            end else begin
               rdata_ff <= 32'h00000000;
            end
         end
         if (wrNow) begin
            if (start) cmd_ff <= avs_writedata[19:0];
            if (avs_address == `OFS_FLAGS && avs_byteenable[0]) flags_ff <= avs_writedata[7:0];
            if (avs_address == `OFS_IMM) imm_ff <= laneMerge(imm_ff, avs_writedata[15:0], avs_byteenable[1:0]);
            if (avs_address == `OFS_DISP) disp_ff <= laneMerge(disp_ff, avs_writedata[15:0], avs_byteenable[1:0]);
            if (avs_address[5] & (avs_address[1:0] == 2'h0)) begin
               gpr_ff[avs_address[4:2]] <= laneMerge(gpr_ff[avs_address[4:2]], avs_writedata[15:0],
                                                     avs_byteenable[1:0]);
            end
         end
         if (state_ff == S_EXE) begin
            flags_ff <= nFl;
            if (wrP) gpr_ff[baseIdx] <= ptrV;
            if (wrW) begin
               gpr_ff[dIdx[2:0]] <= res;
            end else if (wrD & (word | stk)) begin
               gpr_ff[dIdx[2:0]] <= res;
            end else if (wrD & dIdx[3]) begin
               gpr_ff[dIdx[2:0]][7:0] <= res[7:0];
            end else if (wrD) begin
               gpr_ff[dIdx[2:0]][15:8] <= res[7:0];
            end
         end
      end
   end

   assign avs_waitrequest = req & ~ans_ff;
   assign avs_readdata    = rdata_ff;
   assign memReq          = (state_ff == S_RD) | (state_ff == S_WR);
   assign memWe           = state_ff == S_WR;
   assign memByte         = ~(word | stk);
   assign memAddr         = addr_ff;
   assign memWdata        = wd_ff;

endmodule

// File: cpu_alu_sva.sv
// Purpose: port checks of the cpu execution datapath
// Assumes: bound to the datapath top module
// Notes:   one clock domain
`timescale 1ns/1ps
module cpu_alu_sva (
   input wire        ref_clk,
   input wire        sys_rst,
   input wire [5:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire        avs_waitrequest,
   input wire        memReq,
   input wire        memWe,
   input wire        memByte,
   input wire [15:0] memAddr,
   input wire        memAck
);
   // ==========================================
   // cycles since a command was taken
   reg  [4:0] opAge_ff;
   wire       busDone = !avs_waitrequest && (avs_read || avs_write);
   wire [4:0] nxt_opAge = (busDone && avs_write && avs_address == 6'h00) ? 5'h00 :
                          opAge_ff + {4'h0, opAge_ff != 5'h1f};
   always @(posedge ref_clk) begin
      opAge_ff <= sys_rst ? 5'h1f : nxt_opAge;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // assertions
   a_read_prompt: assert property ($rose(avs_read) |=> !avs_waitrequest)
      else $error("read not answered");
   a_idle_free: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
      else $error("wait without request");
   a_answer_gap: assert property (busDone |=> avs_waitrequest || !(avs_read || avs_write))
      else $error("two answers in a row");
   a_mem_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe))
      else $error("memory request changed");
   a_ack_ends: assert property (memReq && memAck |=> !memReq)
      else $error("request after ack");
   a_rmw_addr: assert property ((memReq && memAck && !memWe) ##1 !memReq ##1
      (memReq && memWe) |-> memAddr == $past(memAddr, 2)) else $error("write back moved");
   a_op_bound: assert property (memReq |-> opAge_ff < 5'd20)
      else $error("access outside command");
   a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !memReq && memAddr == 16'h0000)
      else $error("busy after reset");
   c_write: cover property (memReq && memAck && memWe && memByte);
   c_wait: cover property (memReq && !memAck);
   c_cmd: cover property (busDone && avs_write && avs_address == 6'h00);
endmodule

// File: mem_model.sv
// Purpose: memory behind the datapath memory port
// Assumes: byte array, high byte at the lower address
// Notes:   lat sets the wait cycles before memAck
`timescale 1ns/1ps
module mem_model (
   input  wire        ref_clk,
   input  wire        memReq,
   input  wire        memWe,
   input  wire        memByte,
   input  wire [15:0] memAddr,
   input  wire [15:0] memWdata,
   output wire [15:0] memRdata,
   output wire        memAck
);
   // ==========================================
   // storage and answer
   reg  [7:0]  m [0:65535];
   reg  [7:0]  cnt_ff = 8'h00;
   integer     lat = 0;
   wire [15:0] addrNext = memAddr + 16'h0001;
   wire [15:0] word = memByte ? {~m[memAddr], m[memAddr]} : {m[memAddr], m[addrNext]};
   assign memAck = memReq && cnt_ff >= lat;
   assign memRdata = (memAck && !memWe) ? word : ~memAddr ^ {16{cnt_ff[0]}};
   always @(posedge ref_clk) begin
      cnt_ff <= (memReq && !memAck) ? cnt_ff + 8'h01 : 8'h00;
      if (memAck && memWe && memByte)
         m[memAddr] <= memWdata[7:0];
      if (memAck && memWe && !memByte) begin
         m[memAddr] <= memWdata[15:8];
         m[addrNext] <= memWdata[7:0];
      end
   end
endmodule

// File: tb_top.sv
// Purpose: self-checking bench of the cpu execution datapath
// Assumes: memory port answered by mem_model
// Notes:   one command at a time, polled on busy
`timescale 1ns/1ps
module tb_top;
   reg         ref_clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg  [5:0]  avs_address = 6'h00;
   reg         avs_read = 1'b0;
   reg         avs_write = 1'b0;
   reg  [31:0] avs_writedata = 32'h0;
   reg  [3:0]  avs_byteenable = 4'hf;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, memReq, memWe, memByte, memAck;
   wire [15:0] memAddr, memWdata, memRdata;
   reg  [31:0] rq;
   reg  [7:0]  v;
   reg         c, z, bt;
   integer     fails = 0, comparisons = 0, i, k, bn;
   cpu_alu_bit_datapath dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .memReq(memReq), .memWe(memWe), .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck));
   mem_model mem_u (.ref_clk(ref_clk), .memReq(memReq), .memWe(memWe), .memByte(memByte),
      .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck));
   initial forever #2.5 ref_clk = ~ref_clk;
   // ==========================================
   // tasks
   task finish_test;
      begin
         $display("comparisons %0d fails %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task cmp(input string nm, input [31:0] e, input [31:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            fails = fails + 1;
         end
      end
   endtask
   task bus(input w, input [5:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge ref_clk);
         {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, ~w};
         do begin
            @(posedge ref_clk);
            n = n + 1;
         end while (avs_waitrequest !== 1'b0 && n < 100);
         if (n == 100) fails = fails + 1;
         rq = avs_readdata;
         {avs_write, avs_read} <= 2'b00;
      end
   endtask
   task wr(input [5:0] a, input [31:0] d);
      bus(1'b1, a, d);
   endtask
   task ck(input string nm, input [5:0] a, input [31:0] e, input [31:0] mk = 32'hffffffff);
      begin
         bus(1'b0, a, 32'h0);
         cmp(nm, e, rq & mk);
      end
   endtask
   task run(input [31:0] cm, input [31:0] im, input [31:0] dp);
      integer n;
      begin
         wr(6'h08, im);
         wr(6'h0c, dp);
         wr(6'h00, cm);
         rq = 32'hffffffff;
         for (n = 0; n < 40 && rq[31] !== 1'b0; n = n + 1)
            bus(1'b0, 6'h00, 32'h0);
         if (rq[31] !== 1'b0) fails = fails + 1;
      end
   endtask
   function [31:0] mk(input [5:0] op, input [2:0] wim, input [3:0] d, input [3:0] s, input [1:0] md);
      mk = {12'h000, md == 2'h3, md, s, d, wim[2], wim[1], wim[0], op};
   endfunction
   // ==========================================
   // tests
   initial begin
      #200000;
      fails = fails + 1;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      ck("flags", 6'h04, 32'h0);
      wr(6'h10, 32'hffff);
      ck("hole", 6'h10, 32'h0);
      wr(6'h04, 32'h23);
      run(mk(6'h00, 3'h2, 4'h0, 4'h0, 2'h0), 32'h80, 0);
      ck("mov", 6'h20, 32'h8000);
      ck("movf", 6'h04, 32'h29);
      wr(6'h24, 32'h0100);
      mem_u.m[16'h0100] = 8'h00;
      mem_u.m[16'h0101] = 8'h00;
      run(mk(6'h03, 3'h1, 4'h2, 4'h1, 2'h0), 0, 0);
      ck("pinc", 6'h28, 32'h0);
      ck("pptr", 6'h24, 32'h0102);
      ck("pflg", 6'h04, 32'h25);
      wr(6'h2c, 32'h0200);
      run(mk(6'h04, 3'h0, 4'h3, 4'h0, 2'h0), 0, 0);
      ck("pdec", 6'h2c, 32'h01ff);
      cmp("pmem", 32'h80, {24'h0, mem_u.m[16'h01ff]});
      wr(6'h3c, 32'h0300);
      run(mk(6'h06, 3'h1, 4'h0, 4'h1, 2'h0), 0, 0);
      ck("push", 6'h3c, 32'h02fe);
      cmp("smem", 32'h0102, {16'h0, mem_u.m[16'h02fe], mem_u.m[16'h02ff]});
      run(mk(6'h05, 3'h1, 4'h4, 4'h0, 2'h0), 0, 0);
      ck("pop", 6'h30, 32'h0102);
      ck("popsp", 6'h3c, 32'h0300);
      $display("test moves done");
      wr(6'h34, 32'h0fff);
      wr(6'h38, 32'h0001);
      wr(6'h04, 32'h0);
      run(mk(6'h07, 3'h1, 4'h5, 4'h6, 2'h0), 0, 0);
      ck("addw", 6'h34, 32'h1000);
      ck("addh", 6'h04, 32'h20);
      run(mk(6'h0b, 3'h1, 4'h5, 4'h6, 2'h0), 0, 0);
      ck("cmpw", 6'h34, 32'h1000);
      ck("cmph", 6'h04, 32'h20);
      for (i = 0; i < 2; i = i + 1) begin
         wr(6'h04, 32'h01 | (i << 2));
         wr(6'h34, 32'h00ff);
         run(mk(6'h08, 3'h2, 4'hd, 4'h0, 2'h0), 0, 0);
         ck("adcz", 6'h04, 32'h21 | (i << 2));
      end
      wr(6'h34, 32'h009a);
      wr(6'h04, 32'h0);
      run(mk(6'h11, 3'h0, 4'hd, 4'h0, 2'h0), 0, 0);
      ck("daa", 6'h34, 32'h0, 32'hff);
      ck("daaf", 6'h04, 32'h05);
      wr(6'h24, 32'h00fe);
      wr(6'h28, 32'h00ff);
      wr(6'h04, 32'h2b);
      run(mk(6'h13, 3'h0, 4'h9, 4'ha, 2'h0), 0, 0);
      ck("mul", 6'h24, 32'hfd02);
      ck("mulf", 6'h04, 32'h2b);
      wr(6'h24, 32'h0107);
      wr(6'h28, 32'h0090);
      wr(6'h04, 32'h27);
      run(mk(6'h14, 3'h0, 4'h9, 4'ha, 2'h0), 0, 0);
      ck("div", 6'h24, 32'h7701);
      ck("divf", 6'h04, 32'h2b);
      $display("test arithmetic done");
      wr(6'h2c, 32'h00f0);
      v = 8'hf0;
      for (i = 0; i < 4; i = i + 1) begin
         wr(6'h04, 32'h03);
         run(mk(6'h15 + i[5:0], 3'h2, 4'hb, 4'h0, 2'h0), 32'h3c, 0);
         v = i == 0 ? v & 8'h3c : i == 1 ? v | 8'h3c : i == 2 ? v ^ 8'h3c : ~v;
         ck("logic", 6'h2c, {24'h0, v}, 32'hff);
         ck("logf", 6'h04, {28'h0, v[7], v == 8'h00, 2'h1});
      end
      $display("test logic done");
      wr(6'h38, 32'h0400);
      for (i = 0; i < 24; i = i + 1) begin
         k = 6'h19 + i % 12;
         bn = k % 8;
         mem_u.lat = i / 12;
         mem_u.m[16'h0400] = 8'ha5;
         wr(6'h30, 32'h00a5);
         wr(6'h04, 32'h20 | k[0]);
         run(mk(k[5:0], {i >= 12, 2'h2}, i < 12 ? 4'hc : 4'h6, 4'h0, 2'h0), bn, 0);
         v = 8'ha5;
         c = k[0];
         z = 1'b0;
         bt = v[bn];
         case (k)
            6'h19: v[bn] = 1'b1;
            6'h1a: v[bn] = 1'b0;
            6'h1b: v[bn] = ~bt;
            6'h1c: z = ~bt;
            6'h1d: c = bt;
            6'h1e: c = ~bt;
            6'h1f: v[bn] = c;
            6'h20: v[bn] = ~c;
            6'h21: c = c & bt;
            6'h22: c = c & ~bt;
            6'h23: c = c | bt;
            default: c = c | ~bt;
         endcase
         if (i < 12)
            ck("bitr", 6'h30, {24'h0, v}, 32'hff);
         else
            cmp("bitm", {24'h0, v}, {24'h0, mem_u.m[16'h0400]});
         ck("bitf", 6'h04, {26'h0, 1'b1, 2'h0, z, 1'b0, c});
      end
      $display("test bits done");
      wr(6'h24, 32'h0500);
      mem_u.lat = 2;
      for (i = 0; i < 4; i = i + 1) begin
         mem_u.m[i == 0 ? 16'h0500 : i == 1 ? 16'h05f0 : i == 2 ? 16'h04f0 : 16'hfff0] = 8'h11 * (i + 1);
         run(mk(6'h01, 3'h0, 4'ha, 4'h1, i[1:0]), 0, 32'h00f0);
         ck("mode", 6'h28, 8'h11 * (i + 1), 32'hff);
      end
      mem_u.lat = 0;
      wr(6'h34, 32'hffff);
      wr(6'h04, 32'h2f);
      run(mk(6'h0f, 3'h3, 4'h5, 4'h0, 2'h0), 32'h2, 0);
      ck("aadd", 6'h34, 32'h0001);
      ck("aaddf", 6'h04, 32'h2f);
      $display("test addressing done");
      finish_test;
   end
endmodule
bind cpu_alu_bit_datapath cpu_alu_sva chk_u (.*);
